// [design/arb_regs.vh]
/*
  Register offsets, field positions, reset values and timing counts
  for the serial bus arbiter counter. Assumes a 32-bit APB slave with
  byte addresses; all offsets are word aligned.
*/
// Contract
// RQ1 - Nine-bit up-counter with a separate one-bit overflow indication.
// RQ2 - Mode field: 00 idle/reset, 01 measure, 10 arbitrate, 11 reserved.
// RQ3 - Reset clears mode, clock select, lost, done, running, overflow, msb.
// RQ4 - Lost flag read-only; cleared only by writing zero to mode upper bit.
// RQ5 - Clock select: set uses half prescaler clock, clear uses clk/4.
// RQ6 - Prescaler source is bus clock or oscillator clock, by config bit.
// RQ7 - Done flag set at measurement end; any control write clears it.
// RQ8 - Running flag reads one while counting, zero while stopped.
// RQ9 - Overflow flag set on counter overflow; any control write clears it.
// RQ10 - Writing mode 00 resets counter and holds it idle.
// RQ11 - Counter msb readable in control register; any write clears it.
// RQ12 - Measure, clk/4: start on falling rx, stop on next, then set done.
// RQ13 - Measure, prescaler clock: count while rx low, stop on rising rx.
// RQ14 - Arbitrate: restart on tx rise, sample rx at 0x38/0x08, force tx.
// RQ15 - Low counter byte in separate read-only register; write clears.
// RQ16 - Overflow set when counter wraps from maximum; counter stops.
`ifndef ARB_REGS_VH
`define ARB_REGS_VH
`define ARB_CTL_OFF 12'h000
`define ARB_DAT_OFF 12'h004
`define ARB_IST_OFF 12'h008
`define ARB_IMSK_OFF 12'h00c
`define ARB_CFG_OFF 12'h010
`define ARB_PSC_OFF 12'h014
// Control field positions
`define ARB_F_MSB 0
`define ARB_F_OVF 1
`define ARB_F_RUN 2
`define ARB_F_DONE 3
`define ARB_F_CLK 4
`define ARB_F_LOST 5
`define ARB_F_M0 6
`define ARB_F_M1 7
// Modes
`define ARB_MODE_IDLE 2'b00
`define ARB_MODE_MEAS 2'b01
`define ARB_MODE_ARB 2'b10
// Arbitration sample points
`define ARB_SAMPLE_BUS 9'h038
`define ARB_SAMPLE_PSC 9'h008
// Reset values
`define ARB_CTL_RST 8'h00
`define ARB_PSC_RST 8'h01
// Bus clock divider for counter
`define ARB_BUS_DIV 4
`endif

// [design/arb_tick.v]
/*
  Tick generator: one-cycle enable every div cycles of i_clk in which i_en is high.
  Assumes div is at least one; a new div takes effect at the next compare, without waiting for a restart.
*/
`timescale 1ns/100ps
module arb_tick #(
  parameter W = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // Control
  input wire i_en,
  input wire [W-1:0] i_div,
  // Tick
  output reg o_tick
);
  reg [W-1:0] cnt_q;

  always @(posedge i_clk) begin
    if (i_rst) begin
      cnt_q <= {W{1'b0}};
      o_tick <= 1'b0;
    end else if (!i_en) begin
      // Hold the count, so a gated source divides instead of restarting
      o_tick <= 1'b0;
    end else if (cnt_q + {{(W-1){1'b0}}, 1'b1} >= i_div) begin
      cnt_q <= {W{1'b0}};
      o_tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule // arb_tick

// [design/serial_bus_arbiter_counter.v]
/*
  Serial bus arbiter counter: measures bit and break times, arbitrates
  a shared single-wire bus, with an APB register slave and interrupt.
  Assumes rx pin is asynchronous; internal tx line and the oscillator
  tick input are on i_clk.
*/
`timescale 1ns/100ps
`include "arb_regs.vh"
module serial_bus_arbiter_counter (
  // Clock and reset
  input wire i_clk,
  input wire i_rst,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Serial lines
  input wire i_rx_pin,
  input wire i_internal_transmit_line,
  input wire i_osc_tick,
  output wire o_tx_pin,
  // Interrupt
  output wire o_irq
);
  // Control fields
  reg [1:0] mode_q;
  reg clk_sel_q;
  reg lost_q;
  reg done_q;
  reg run_q;
  reg ovf_q;
  reg [8:0] cnt_q;
  reg [3:0] ist_q;
  reg [3:0] imsk_q;
  reg src_sel_q;
  reg [7:0] psc_div_q;
  // Rx sync and edges
  reg rx_s1_q;
  reg rx_s2_q;
  reg rx_prev_q;
  reg tx_prev_q;
  reg [1:0] div4_q;
  reg half_q;
  reg meas_armed_q;
  reg arb_act_q;
  reg sampled_q;
  wire psc_tick;
  wire psc_src_tick;
  wire cnt_tick;
  wire wr;
  wire rd;
  wire ctl_wr;
  wire rx_fall;
  wire rx_rise;
  wire tx_rise;
  wire tx_fall;
  wire [8:0] sample_pt;
  wire [7:0] ctl_rd;
  wire done_ev;
  wire ovf_ev;
  wire lost_ev;
  wire wrap;

  // Zero-wait APB; writes take effect in the access phase, reads sample in the setup phase
  assign o_pready = 1'b1;
  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && i_penable && !i_pwrite;
  assign ctl_wr = wr && (i_paddr == `ARB_CTL_OFF);
  assign o_pslverr = i_psel && i_penable &&
    !(i_paddr == `ARB_CTL_OFF || i_paddr == `ARB_DAT_OFF ||
      i_paddr == `ARB_IST_OFF || i_paddr == `ARB_IMSK_OFF ||
      i_paddr == `ARB_CFG_OFF || i_paddr == `ARB_PSC_OFF);

  // Two flops before any logic reads the pin
  always @(posedge i_clk) begin
    if (i_rst) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_prev_q <= 1'b1;
      tx_prev_q <= 1'b1;
    end else begin
      rx_s1_q <= i_rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_prev_q <= rx_s2_q;
      tx_prev_q <= i_internal_transmit_line;
    end
  end
  assign rx_fall = rx_prev_q && !rx_s2_q;
  assign rx_rise = !rx_prev_q && rx_s2_q;
  assign tx_rise = !tx_prev_q && i_internal_transmit_line;
  assign tx_fall = tx_prev_q && !i_internal_transmit_line;

  // Prescaler source: bus clock or oscillator tick [RQ6]
  assign psc_src_tick = src_sel_q ? i_osc_tick : 1'b1;

  arb_tick #(
    .W(8)
  ) u_psc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_en(psc_src_tick),
    .i_div(psc_div_q),
    .o_tick(psc_tick)
  );

  // Oscillator source gates the prescaler, so a stalled tick stalls it
  always @(posedge i_clk) begin
    if (i_rst) begin
      div4_q <= 2'b00;
      half_q <= 1'b0;
    end else begin
      div4_q <= div4_q + 2'b01;
      if (psc_tick) begin
        half_q <= !half_q;
      end
    end
  end
  // Counter clock select [RQ5]
  assign cnt_tick = clk_sel_q ? (psc_tick && half_q) : (div4_q == 2'b11);

  assign sample_pt = clk_sel_q ? `ARB_SAMPLE_PSC : `ARB_SAMPLE_BUS;
  assign wrap = (cnt_q == 9'h1ff) && cnt_tick && run_q;
  assign ovf_ev = wrap;
  assign done_ev = (mode_q == `ARB_MODE_MEAS) && run_q &&
    ((!clk_sel_q && rx_fall) || (clk_sel_q && rx_rise));
  assign lost_ev = (mode_q == `ARB_MODE_ARB) && arb_act_q && !sampled_q &&
    (cnt_q == sample_pt) && !rx_s2_q;

  // Counter and mode engine
  always @(posedge i_clk) begin
    if (i_rst) begin
      mode_q <= `ARB_MODE_IDLE; // [RQ3]
      clk_sel_q <= 1'b0;
      lost_q <= 1'b0;
      done_q <= 1'b0;
      run_q <= 1'b0;
      ovf_q <= 1'b0;
      cnt_q <= 9'h000;
      meas_armed_q <= 1'b0;
      arb_act_q <= 1'b0;
      sampled_q <= 1'b0;
    end else if (ctl_wr) begin
      mode_q <= {i_pwdata[`ARB_F_M1], i_pwdata[`ARB_F_M0]}; // [RQ2]
      clk_sel_q <= i_pwdata[`ARB_F_CLK];
      // Lost survives any write that keeps mode upper bit set [RQ4]
      if (!i_pwdata[`ARB_F_M1]) begin
        lost_q <= 1'b0;
      end
      done_q <= 1'b0; // [RQ7]
      ovf_q <= 1'b0; // [RQ9]
      cnt_q <= 9'h000; // [RQ11] [RQ15]
      run_q <= 1'b0;
      meas_armed_q <= 1'b1;
      arb_act_q <= 1'b0;
      sampled_q <= 1'b0;
    end else begin
      case (mode_q)
        `ARB_MODE_MEAS: begin
          if (run_q) begin
            if (done_ev) begin
              run_q <= 1'b0; // [RQ12] [RQ13]
              done_q <= 1'b1;
              meas_armed_q <= 1'b0;
            end else if (wrap) begin
              run_q <= 1'b0; // [RQ16]
              ovf_q <= 1'b1;
              meas_armed_q <= 1'b0;
            end else if (cnt_tick) begin
              cnt_q <= cnt_q + 9'h001; // [RQ1]
            end
          end else if (meas_armed_q) begin
            // Level start with prescaler clock catches rx already low
            if ((!clk_sel_q && rx_fall) || (clk_sel_q && !rx_s2_q)) begin
              run_q <= 1'b1; // [RQ8] [RQ12] [RQ13]
            end
          end
        end
        `ARB_MODE_ARB: begin
          if (tx_rise) begin
            cnt_q <= 9'h000; // [RQ14]
            run_q <= 1'b1;
            arb_act_q <= 1'b1;
            sampled_q <= 1'b0;
          end else if (tx_fall && !sampled_q) begin
            // Tx low before bus was sensed: restart on next rise
            cnt_q <= 9'h000;
            run_q <= 1'b0;
            arb_act_q <= 1'b0;
          end else if (run_q) begin
            if (cnt_q == sample_pt && arb_act_q && !sampled_q) begin
              sampled_q <= 1'b1;
              if (!rx_s2_q) begin
                lost_q <= 1'b1; // [RQ14]
              end
            end
            if (wrap) begin
              run_q <= 1'b0; // [RQ16]
              ovf_q <= 1'b1;
            end else if (cnt_tick) begin
              cnt_q <= cnt_q + 9'h001;
            end
          end
        end
        default: begin
          // Idle and reserved hold the counter cleared [RQ10]
          cnt_q <= 9'h000;
          run_q <= 1'b0;
          arb_act_q <= 1'b0;
          sampled_q <= 1'b0;
        end
      endcase
    end
  end

  // Seized transmission while lost is set [RQ14]
  assign o_tx_pin = lost_q ? 1'b1 : i_internal_transmit_line;

  // Sticky interrupt status, write one to clear; set wins
  always @(posedge i_clk) begin
    if (i_rst) begin
      ist_q <= 4'h0;
      imsk_q <= 4'h0;
      src_sel_q <= 1'b0;
      psc_div_q <= `ARB_PSC_RST;
    end else begin
      ist_q <= (ist_q & ~((wr && i_paddr == `ARB_IST_OFF) ?
        i_pwdata[3:0] : 4'h0)) |
        {lost_ev, (mode_q == `ARB_MODE_MEAS) && run_q && cnt_tick &&
         cnt_q == 9'h000, ovf_ev, done_ev};
      if (wr && i_paddr == `ARB_IMSK_OFF) begin
        imsk_q <= i_pwdata[3:0];
      end
      if (wr && i_paddr == `ARB_CFG_OFF) begin
        src_sel_q <= i_pwdata[0];
      end
      if (wr && i_paddr == `ARB_PSC_OFF) begin
        psc_div_q <= i_pwdata[7:0];
      end
    end
  end
  assign o_irq = |(ist_q & imsk_q);

  assign ctl_rd = {mode_q, lost_q, clk_sel_q, done_q, run_q, ovf_q,
    cnt_q[8]};

  // Registered read data
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      case (i_paddr)
        `ARB_CTL_OFF: o_prdata <= {24'h000000, ctl_rd}; // [RQ11]
        `ARB_DAT_OFF: o_prdata <= {24'h000000, cnt_q[7:0]}; // [RQ15]
        `ARB_IST_OFF: o_prdata <= {28'h0000000, ist_q};
        `ARB_IMSK_OFF: o_prdata <= {28'h0000000, imsk_q};
        `ARB_CFG_OFF: o_prdata <= {31'h00000000, src_sel_q};
        `ARB_PSC_OFF: o_prdata <= {24'h000000, psc_div_q};
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule // serial_bus_arbiter_counter

// [verif/arb_chk.sv]
/* Port checker for the arbiter counter.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module arb_chk (
  input wire i_clk, input wire i_rst,
  input wire i_psel, input wire i_penable, input wire i_pwrite,
  input wire [11:0] i_paddr, input wire [31:0] o_prdata,
  input wire o_pready, input wire o_pslverr,
  input wire i_internal_transmit_line, input wire o_tx_pin,
  input wire o_irq
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  wire acc = i_psel && i_penable;
  wire bad = i_paddr > 12'h014;
  sequence rd_setup; i_psel && !i_penable && !i_pwrite; endsequence
  sequence rd_bad; rd_setup ##0 bad ##1 acc; endsequence
  ready_hi_a: assert property (acc |-> o_pready) else $error("ready low");
  err_bad_a: assert property (acc && bad |-> o_pslverr)
    else $error("no slave error");
  err_good_a: assert property (acc && !bad && i_paddr[1:0] == 2'b00
    |-> !o_pslverr) else $error("spurious slave error");
  rd_bad_a: assert property (rd_bad |-> o_prdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(i_psel && !i_penable && !i_pwrite)
    |=> $stable(o_prdata)) else $error("read data moved");
  rst_rdata_a: assert property (disable iff (1'b0)
    i_rst |=> o_prdata == 32'h0) else $error("read data after reset");
  rst_irq_a: assert property (disable iff (1'b0)
    i_rst |=> !o_irq) else $error("irq after reset");
  tx_force_a: assert property (
    o_tx_pin != i_internal_transmit_line |-> o_tx_pin)
    else $error("tx forced low");
  tx_rst_a: assert property (disable iff (1'b0)
    i_rst |=> o_tx_pin == i_internal_transmit_line)
    else $error("tx forced after reset");
endmodule // arb_chk
bind serial_bus_arbiter_counter arb_chk u_chk (.*);

// [verif/bus_node.sv]
/* Far-side model: the shared single-wire bus with other nodes.
   Assumes a wired-AND line that idles recessive high. */
`timescale 1ns/100ps
module bus_node (
  // Our node and the others
  input wire i_tx_pin,
  input wire i_dominant,
  // Bus level seen back
  output wire o_rx
);
  // Any node driving dominant wins; released line pulls high
  assign o_rx = i_tx_pin & ~i_dominant;
endmodule // bus_node

// [verif/tb.sv]
/* Self-checking bench for the arbiter counter over APB.
   Assumes zero-wait APB and rx seen a few cycles after the pin. */
`timescale 1ns/100ps
module tb;
  reg clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, txl = 1, dom = 0;
  reg osc = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwd = 0, d;
  reg err;
  wire [31:0] prd;
  wire rdy, slv, rx, txp, irq;
  integer error_cnt = 0, tests_run = 0;
  always #10 clk = ~clk;
  // Oscillator enable: one pulse every other bus cycle
  always @(posedge clk) osc <= ~osc;
  serial_bus_arbiter_counter u_serial_bus_arbiter_counter (.i_clk(clk),
    .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy),
    .o_pslverr(slv), .i_rx_pin(rx), .i_internal_transmit_line(txl),
    .i_osc_tick(osc), .o_tx_pin(txp), .o_irq(irq));
  bus_node u_bus_node (.i_tx_pin(txp), .i_dominant(dom), .o_rx(rx));
  task chk(input [31:0] s, input [31:0] e); begin
    tests_run = tests_run + 1;
    if (s !== e) begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: saw %h want %h", $time, s, e);
    end
  end endtask
  task apb(input w, input [11:0] a, input [31:0] wd); begin
    @(posedge clk); psel <= 1; pwr <= w; paddr <= a; pwd <= wd;
    @(posedge clk); pen <= 1;
    // Only the watchdog ends a wait for ready
    do @(posedge clk); while (rdy !== 1'b1);
    d = prd; err = slv;
    psel <= 0; pen <= 0;
  end endtask
  task wn(input integer k); repeat (k) @(posedge clk); endtask
  task t_reset; begin
    apb(0, 12'h000, 0); chk(d, 32'h0);
    apb(0, 12'h004, 0); chk(d, 32'h0);
    apb(0, 12'h014, 0); chk(d, 32'h1);
    apb(0, 12'h020, 0); chk(d, 32'h0);
    chk(err, 1'b1);
    $display("t_reset done");
  end endtask
  task t_meas; begin
    apb(1, 12'h00c, 32'h1); apb(1, 12'h000, 32'h40);
    dom <= 1; wn(40); dom <= 0; wn(40);
    apb(0, 12'h000, 0); chk(d[3:2], 2'b01);
    dom <= 1; wn(10);
    apb(0, 12'h000, 0); chk(d[3:2], 2'b10);
    dom <= 0; chk(irq, 1'b1);
    apb(0, 12'h004, 0); chk(d > 18 && d < 23, 1);
    apb(1, 12'h008, 32'hf); wn(1); chk(irq, 1'b0);
    apb(1, 12'h000, 32'h40); apb(0, 12'h000, 0);
    chk(d[7:0], 8'h40);
    apb(0, 12'h004, 0); chk(d, 32'h0);
    $display("t_meas done");
  end endtask
  task t_ovf; begin
    apb(1, 12'h000, 32'h40); dom <= 1; wn(2); dom <= 0; wn(2100);
    apb(0, 12'h000, 0); chk(d[7:0], 8'h43);
    apb(0, 12'h004, 0); chk(d, 32'hff);
    apb(1, 12'h000, 32'h0); apb(0, 12'h000, 0);
    chk(d, 32'h0);
    dom <= 1; wn(20); dom <= 0; wn(20); dom <= 1; wn(20); dom <= 0;
    apb(0, 12'h004, 0); chk(d, 32'h0);
    $display("t_ovf done");
  end endtask
  task t_arb; begin
    apb(1, 12'h00c, 32'h8); apb(1, 12'h000, 32'h80);
    txl <= 0; wn(8); txl <= 1; dom <= 1; wn(250);
    apb(0, 12'h000, 0); chk(d[5], 1'b1);
    txl <= 0; wn(1); chk({txp, irq}, 2'b11);
    apb(1, 12'h000, 32'h80); apb(0, 12'h000, 0);
    chk(d[5], 1'b1);
    apb(1, 12'h000, 32'h0); apb(0, 12'h000, 0);
    chk({d[5], txp}, 2'b00);
    dom <= 0; apb(1, 12'h008, 32'hf);
    $display("t_arb done");
  end endtask
  task t_psc; begin
    txl <= 1; apb(1, 12'h010, 32'h1); dom <= 1;
    apb(1, 12'h000, 32'h50); wn(60);
    apb(0, 12'h000, 0); chk(d[4:2], 3'b101);
    dom <= 0; wn(10);
    apb(0, 12'h000, 0); chk(d[3:2], 2'b10);
    apb(0, 12'h004, 0); chk(d >= 14 && d <= 18, 1);
    apb(1, 12'h000, 32'h0); apb(1, 12'h010, 32'h0);
    apb(1, 12'h008, 32'hf);
    $display("t_psc done");
  end endtask
  task close_out; begin
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  end endtask
  initial begin
    wn(2); rst <= 0;
    t_reset; t_meas; t_ovf; t_arb; t_psc;
    close_out;
  end
  initial begin
    wn(20000); error_cnt = error_cnt + 1; close_out;
  end
endmodule // tb
